/* File: hbs_host_port.sv */
// Host parallel port: register slave, interrupt acknowledge chain (i_irq_vector is not driven out) and bus arbitration.
// Assumes external wire logic resolves open-drain pins from the output enables.
`timescale 1ns/1ps
// Operation
// R1: Register access only while chip_select_n low; otherwise ignored.
// R2: As master, drive address_strobe_n marking address and direction valid.
// R3: As slave, data_strobe_n captures write data or enables read data.
// R4: As master, drive data_strobe_n to pace each memory transfer.
// R5: As slave, sample read_not_write while select and strobe active.
// R6: As master, drive read_not_write for memory read or write.
// R7: As slave, pull transfer_ack_n low when register access completes.
// R8: After bus request, wait on transfer_ack_n for bus idle first.
// R9: As master, hold each cycle until transfer_ack_n asserted.
// R10: As slave, read operand_size to learn the operand width.
// R11: Interrupt acknowledge needs int_ack_in_n, data strobe and address match.
// R12: Pass acknowledge down via int_ack_pass_n when no interrupt pending.
// R13: Three open-drain request lines: modem, transmit, receive.
// R14: Pull bus_request_n low when bus mastership is needed.
// R15: Arbiter asserts grant_in_n when bus becomes available.
// R16: grant_pass_n low exactly when grant_in_n low and no request.
// R17: Priority arbitration routes grants externally to chosen device.
// R18: Sample mastership_held_n for others; drive it while master.
// R19: On bus_fault_n as master, end cycle, release bus, flag error.
// R20: data_buffer_enable_n low when master or select and strobe low.
// R21: operand_size: 0 byte, 1 word, 2 long, 3 reserved.
// R22: Cascade pass outputs to next device inputs.
module hbs_host_port
  import hbs_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_resetn,
  // Host bus pins
  input  wire logic                   i_chip_select_n,
  input  wire logic                   i_data_strobe_n,
  input  wire logic                   i_read_not_write,
  input  wire logic [1:0]             i_operand_size,
  input  wire logic [7:0]             i_addr,
  input  wire logic [15:0]            i_data,
  input  wire logic                   i_transfer_ack_n,
  output logic                        o_transfer_ack_oe,
  output logic                        o_address_strobe_n,
  output logic                        o_data_strobe_n,
  output logic                        o_read_not_write,
  output logic                        o_strobe_oe,
  output logic [7:0]                  o_addr,
  output logic [15:0]                 o_data,
  output logic                        o_data_oe,
  output logic                        o_data_buffer_enable_n,
  // Interrupt pins
  input  wire logic                   i_int_ack_in_n,
  output logic                        o_int_ack_pass_n,
  output logic [HBS_NUM_IRQ-1:0]      o_int_request_oe,
  // Arbitration pins
  output logic                        o_bus_request_oe,
  input  wire logic                   i_grant_in_n,
  output logic                        o_grant_pass_n,
  input  wire logic                   i_mastership_held_n,
  output logic                        o_mastership_held_oe,
  input  wire logic                   i_bus_fault_n,
  // Register side
  output logic                        o_reg_req_valid,
  output hbs_slv_req_s                o_reg_req,
  input  wire logic [15:0]            i_reg_rdata,
  // Interrupt side
  input  wire logic [HBS_NUM_IRQ-1:0] i_irq_pending,
  input  wire logic [7:0]             i_irq_vector,
  output logic                        o_iack_pulse,
  // DMA side
  input  wire logic                   i_dma_req_valid,
  input  wire hbs_dma_req_s           i_dma_req,
  output logic                        o_dma_done,
  output logic [15:0]                 o_dma_rdata,
  output logic                        o_bus_fault_irq
);

  // Synchronised pins
  localparam int SW = 34;
  logic [SW-1:0] pin_a;
  logic [SW-1:0] pin_s;
  assign pin_a = {i_chip_select_n, i_data_strobe_n, i_read_not_write, i_operand_size,
                  i_addr, i_data, i_transfer_ack_n, i_int_ack_in_n, i_grant_in_n,
                  i_mastership_held_n, i_bus_fault_n};

  hbs_sync #(.W(SW), .RST({3'h7, 2'h0, 8'h00, 16'h0000, 5'h1f})) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   (pin_a),
    .o_sync    (pin_s)
  );

  wire        cs_n   = pin_s[33];
  wire        ds_n   = pin_s[32];
  wire        rnw    = pin_s[31];
  wire [1:0]  siz    = pin_s[30:29];
  wire [7:0]  addr   = pin_s[28:21];
  wire [15:0] data   = pin_s[20:5];
  wire        ack_n  = pin_s[4];
  wire        iack_n = pin_s[3];
  wire        bg_n   = pin_s[2];
  wire        bgk_n  = pin_s[1];
  wire        bus_fault_n_n = pin_s[0];

  // Master, slave and interrupt state
  hbs_mstate_e st_r;
  hbs_mstate_e st_nxt;
  logic        fault_r;
  logic        busy_r;
  logic [HBS_ACK_DLY_CYC:0] ack_dly_r;
  logic        ack_oe_r;
  logic [15:0] rdata_r;
  logic        iack_act_r;
  logic [15:0] dma_rdata_r;
  hbs_dma_req_s dreq_r;

  wire master   = (st_r == HBS_M_ADDR) || (st_r == HBS_M_DATA);
  wire slv_sel  = !cs_n && !ds_n && !master;                              // see R1
  wire iack_hit = !iack_n && !ds_n && (addr[6:0] == HBS_IACK_ADDR);       // see R11
  wire any_irq  = |i_irq_pending;
  wire req_int  = (st_r == HBS_M_REQ) || i_dma_req_valid && (st_r == HBS_M_IDLE);

  // Slave access: direction and size sampled with strobe, completion acknowledged
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_r          <= 1'b0;
      ack_dly_r       <= '0;
      ack_oe_r        <= 1'b0;
      o_reg_req_valid <= 1'b0;
      o_reg_req       <= '0;
      rdata_r         <= 16'h0000;
    end else begin
      o_reg_req_valid <= slv_sel && !busy_r;                              // see R3
      if (slv_sel && !busy_r) begin
        o_reg_req <= '{read: rnw, size: siz, addr: addr, wdata: data};    // see R5, R10, R21
      end
      busy_r    <= slv_sel;
      ack_dly_r <= {ack_dly_r[HBS_ACK_DLY_CYC-1:0], slv_sel && !busy_r};
      if (ack_dly_r[HBS_ACK_DLY_CYC]) begin
        rdata_r  <= i_reg_rdata;
        ack_oe_r <= 1'b1;                                                 // see R7
      end else if (!slv_sel) begin
        ack_oe_r <= 1'b0;
      end
    end
  end

  // Interrupt acknowledge capture
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      iack_act_r <= 1'b0;
    end else begin
      iack_act_r <= iack_hit && any_irq;
    end
  end
  assign o_iack_pulse     = iack_hit && any_irq && !iack_act_r;
  assign o_int_ack_pass_n = !(iack_hit && !any_irq);                      // see R12
  assign o_int_request_oe = i_irq_pending;                                // see R13

  // Bus master engine
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HBS_M_IDLE: if (i_dma_req_valid) st_nxt = HBS_M_REQ;                // see R14
      HBS_M_REQ:  if (!bg_n && bgk_n && ack_n) st_nxt = HBS_M_ADDR;       // see R8, R18
      HBS_M_ADDR: st_nxt = bus_fault_n_n ? HBS_M_DATA : HBS_M_DONE;              // see R2
      HBS_M_DATA: begin
        if (!bus_fault_n_n || !ack_n) st_nxt = HBS_M_DONE;                       // see R9, R19
      end
      HBS_M_DONE: st_nxt = HBS_M_IDLE;
      default:    st_nxt = HBS_M_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r        <= HBS_M_IDLE;
      fault_r     <= 1'b0;
      dreq_r      <= '0;
      dma_rdata_r <= 16'h0000;
    end else begin
      st_r    <= st_nxt;
      fault_r <= master && !bus_fault_n_n;                                       // see R19
      if (st_r == HBS_M_IDLE && i_dma_req_valid) dreq_r <= i_dma_req;
      if (st_r == HBS_M_DATA && !ack_n && dreq_r.read) dma_rdata_r <= data;
    end
  end

  assign o_bus_fault_irq = fault_r;
  assign o_dma_done      = (st_r == HBS_M_DONE);
  assign o_dma_rdata     = dma_rdata_r;

  // Pin drive
  assign o_bus_request_oe       = req_int;                                // see R14
  assign o_grant_pass_n         = !(!bg_n && !req_int);                   // see R16
  assign o_mastership_held_oe   = master;                                 // see R18
  assign o_strobe_oe            = master;
  assign o_address_strobe_n     = !master;                                // see R2
  assign o_data_strobe_n        = !(st_r == HBS_M_DATA);                  // see R4
  assign o_read_not_write       = master ? dreq_r.read : 1'b1;            // see R6
  assign o_addr                 = dreq_r.addr_lo;
  assign o_data                 = master ? dreq_r.wdata : rdata_r;
  assign o_data_oe              = (master && !dreq_r.read) || (ack_oe_r && o_reg_req.read);
  assign o_transfer_ack_oe      = ack_oe_r && !master;                    // see R7
  assign o_data_buffer_enable_n = !(master || (!cs_n && !ds_n));          // see R20

  // Assertions
  localparam int ACK_CHK_DLY = HBS_ACK_DLY_CYC + 2;

  sequence s_req_wait;
    st_r == HBS_M_REQ;
  endsequence

  chk_grant_pass: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R16
    o_bus_request_oe |-> o_grant_pass_n)
    else $error("grant passed while requesting");
  chk_master_wait: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R8
    s_req_wait ##1 (st_r == HBS_M_ADDR) |-> $past(ack_n) && !$past(bg_n))
    else $error("mastership taken while bus busy");
  chk_cycle_ext: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R9
    (st_r == HBS_M_DATA) && ack_n && bus_fault_n_n |=> (st_r == HBS_M_DATA))
    else $error("master cycle ended without acknowledge");
  chk_fault_rel: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R19
    master && !bus_fault_n_n |=> o_bus_fault_irq ##1 !master)
    else $error("bus fault not handled");
  chk_iack_pass: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R12
    iack_hit && !any_irq |-> !o_int_ack_pass_n)
    else $error("acknowledge not passed");
  chk_ack_done: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R7
    slv_sel && !busy_r && !master |-> ##ACK_CHK_DLY o_transfer_ack_oe || !slv_sel)
    else $error("slave access not acknowledged");
  chk_no_cs: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R1
    cs_n |=> !o_reg_req_valid)
    else $error("access taken without select");
  chk_buf_en: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // see R20
    master |-> !o_data_buffer_enable_n)
    else $error("buffers off while master");
endmodule

/* File: hbs_pkg.sv */
// Package for the host bus slave and arbitration block.
// Assumes a single 100 MHz system clock; all pins are synchronised in the top.
package hbs_pkg;

  // Operand size encoding on operand_size[1:0]
  localparam logic [1:0] HBS_SIZE_BYTE = 2'h0;
  localparam logic [1:0] HBS_SIZE_WORD = 2'h1;
  localparam logic [1:0] HBS_SIZE_LONG = 2'h2;
  localparam logic [1:0] HBS_SIZE_RSVD = 2'h3;

  // Interrupt acknowledge address match on A[6:0]
  localparam logic [6:0] HBS_IACK_ADDR = 7'h7f;

  // Interrupt request line indices
  localparam int HBS_IRQ_MODEM = 0;
  localparam int HBS_IRQ_TX    = 1;
  localparam int HBS_IRQ_RX    = 2;
  localparam int HBS_NUM_IRQ   = 3;

  // Timing
  localparam int HBS_CLK_NS       = 10;
  localparam int HBS_ACK_DLY_NS   = 20;
  localparam int HBS_ACK_DLY_CYC  = (HBS_ACK_DLY_NS + HBS_CLK_NS - 1) / HBS_CLK_NS;
  localparam int HBS_SYNC_STAGES  = 2;

  // Master engine states, one-hot
  typedef enum logic [4:0] {
    HBS_M_IDLE = 5'h01,
    HBS_M_REQ  = 5'h02,
    HBS_M_ADDR = 5'h04,
    HBS_M_DATA = 5'h08,
    HBS_M_DONE = 5'h10
  } hbs_mstate_e;

  // Slave access request carried to the register side
  typedef struct packed {
    logic        read;
    logic [1:0]  size;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } hbs_slv_req_s;

  // Master transfer request from DMA
  typedef struct packed {
    logic        read;
    logic [7:0]  addr_lo;
    logic [15:0] wdata;
  } hbs_dma_req_s;

endpackage

/* File: hbs_sync.sv */
// Two-flop synchroniser, parameterised width.
// Assumes inputs are asynchronous to i_sys_clk.
`timescale 1ns/1ps
module hbs_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  // Data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= RST;
      o_sync <= RST;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

/* File: hbs_arb_model.sv */
// Arbiter and system memory model facing the host port when it is master.
// Assumes the bench resolves the open-drain lines from all enables.
`timescale 1ns/1ps
module hbs_arb_model (
  input  wire logic        i_clk,
  input  wire logic        i_bus_request_n,
  input  wire logic        i_grant_force,
  input  wire logic        i_strobe_oe,
  input  wire logic        i_data_strobe_n,
  input  wire logic        i_read_not_write,
  input  wire logic [15:0] i_wdata,
  input  wire logic [15:0] i_mem_word,
  input  wire logic [3:0]  i_ack_wait,
  input  wire logic        i_ack_off,
  output logic             o_grant_in_n = 1'b1,
  output logic             o_ack_oe = 1'b0,
  output logic [15:0]      o_rdata,
  output logic [15:0]      o_wseen = 16'h0
);
  logic [3:0]  cnt = 4'h0;
  logic [15:0] noise = 16'h5a5a;
  // Grant one cycle after request, or passed down from upstream
  always @(posedge i_clk) o_grant_in_n <= i_bus_request_n & ~i_grant_force;
  // Ack only inside a master data strobe, released otherwise
  always @(posedge i_clk) begin
    noise <= ~noise;
    if (!(i_strobe_oe && !i_data_strobe_n)) begin
      cnt <= 4'h0;
      o_ack_oe <= 1'b0;
    end else if (cnt == i_ack_wait && !i_ack_off) begin
      o_ack_oe <= 1'b1;
      if (!i_read_not_write) o_wseen <= i_wdata;
    end else if (cnt != i_ack_wait) begin
      cnt <= cnt + 4'h1;
    end
  end
  // Released data bus shows a changing pattern
  assign o_rdata = o_ack_oe ? i_mem_word : noise;
endmodule

/* File: host_bus_slave_and_arbitration_bench.sv */
// Bench for the host port: slave access, interrupt chain, arbitration, faults.
// Assumes the package, design files and hbs_arb_model are compiled first.
`timescale 1ns/1ps
module host_bus_slave_and_arbitration_bench;
  import hbs_pkg::*;
  logic         clk, resetn, cs_n, ds_n, rnw, iack_n, fault_n, dma_v, gforce, ack_off;
  logic         ack_oe, as_n, mds_n, mrnw, s_oe, d_oe, den_n, pass_n, br_oe, gpass_n, mh_oe;
  logic         rq_v, iack_p, done, flt, grant_n, arb_ack, m_rnw;
  logic [1:0]   size;
  logic [2:0]   pend, irq_oe;
  logic [3:0]   ack_wait;
  logic [7:0]   addr, maddr, m_addr;
  logic [15:0]  hdata, rdreg, memw, mdata, dma_rd, arb_rd, wseen;
  logic [31:0]  seed = 32'h59456071;
  hbs_slv_req_s rq, req_q;
  hbs_dma_req_s dreq;
  int           mismatches = 0, samples_checked = 0, req_n = 0, iack_cnt = 0;
  int           flt_cnt = 0, mh_cnt = 0, done_cnt = 0;
  wire          tack_n = ~(ack_oe | arb_ack);
  wire [15:0]   xdata = s_oe ? arb_rd : hdata;

  hbs_host_port i_dut (.i_sys_clk(clk), .i_resetn(resetn), .i_chip_select_n(cs_n),
    .i_data_strobe_n(ds_n), .i_read_not_write(rnw), .i_operand_size(size), .i_addr(addr),
    .i_data(xdata), .i_transfer_ack_n(tack_n), .o_transfer_ack_oe(ack_oe),
    .o_address_strobe_n(as_n), .o_data_strobe_n(mds_n), .o_read_not_write(mrnw),
    .o_strobe_oe(s_oe), .o_addr(maddr), .o_data(mdata), .o_data_oe(d_oe),
    .o_data_buffer_enable_n(den_n), .i_int_ack_in_n(iack_n), .o_int_ack_pass_n(pass_n),
    .o_int_request_oe(irq_oe), .o_bus_request_oe(br_oe), .i_grant_in_n(grant_n),
    .o_grant_pass_n(gpass_n), .i_mastership_held_n(~mh_oe), .o_mastership_held_oe(mh_oe),
    .i_bus_fault_n(fault_n), .o_reg_req_valid(rq_v), .o_reg_req(rq), .i_reg_rdata(rdreg),
    .i_irq_pending(pend), .i_irq_vector(8'h00), .o_iack_pulse(iack_p),
    .i_dma_req_valid(dma_v), .i_dma_req(dreq), .o_dma_done(done), .o_dma_rdata(dma_rd),
    .o_bus_fault_irq(flt));
  hbs_arb_model i_arb (.i_clk(clk), .i_bus_request_n(~br_oe), .i_grant_force(gforce),
    .i_strobe_oe(s_oe), .i_data_strobe_n(mds_n), .i_read_not_write(mrnw), .i_wdata(mdata),
    .i_mem_word(memw), .i_ack_wait(ack_wait), .i_ack_off(ack_off), .o_grant_in_n(grant_n),
    .o_ack_oe(arb_ack), .o_rdata(arb_rd), .o_wseen(wseen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Event monitor
  always @(posedge clk) begin
    if (rq_v === 1'b1) req_q <= rq;
    if (rq_v === 1'b1) req_n <= req_n + 1;
    if (iack_p === 1'b1) iack_cnt <= iack_cnt + 1;
    if (flt === 1'b1) flt_cnt <= flt_cnt + 1;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (mh_oe === 1'b1) mh_cnt <= mh_cnt + 1;
    if (s_oe === 1'b1 && as_n === 1'b0) m_rnw <= mrnw;
    if (s_oe === 1'b1 && as_n === 1'b0) m_addr <= maddr;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic exp_pass_n(input logic hit, input logic [2:0] p);
    return !(hit && p == 3'h0);
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic slave(input logic rd, input logic [1:0] sz, input logic [7:0] a,
                       input logic [15:0] wd);
    int n;
    n = req_n;
    step();
    {rnw, size, addr, hdata, rdreg} = {rd, sz, a, wd, ~wd};
    {cs_n, ds_n} = 2'b00;
    for (int i = 0; i < 20 && ack_oe !== 1'b1; i++) step();
    check("ack", 1, ack_oe);
    check("den", 0, den_n);
    check("req_n", n + 1, req_n);
    check("req", {rd, sz, a}, {req_q.read, req_q.size, req_q.addr});
    check("dat", rd ? {1'b1, ~wd} : {1'b0, wd}, rd ? {d_oe, mdata} : {d_oe, req_q.wdata});
    {cs_n, ds_n} = 2'b11;
    for (int i = 0; i < 10 && ack_oe === 1'b1; i++) step();
    check("ack_drop", 0, ack_oe);
  endtask
  task automatic dma(input logic rd, input logic [3:0] w);
    int d, m;
    {d, m} = {done_cnt, mh_cnt};
    seed = lfsr(seed);
    step();
    {ack_wait, memw, dreq} = {w, seed[15:0], rd, seed[23:16], seed[31:16]};
    dma_v = 1'b1;
    step();
    for (int i = 0; i < 10 && br_oe !== 1'b1; i++) step();
    check("br", 1, br_oe);
    check("gpass_req", 1, gpass_n);
    dma_v = 1'b0;
    for (int i = 0; i < 60 && done_cnt == d; i++) step();
    check("done", d + 1, done_cnt);
    check("master", {rd, seed[23:16]}, {m_rnw, m_addr});
    check("mdata", rd ? memw : seed[31:16], rd ? dma_rd : wseen);
    check("held", 1, mh_cnt > m);
  endtask

  initial begin
    int n;
    {cs_n, ds_n, iack_n, fault_n, rnw, resetn} = 6'b111110;
    {dma_v, gforce, ack_off, size, addr, hdata, rdreg, pend, dreq} = '0;
    {ack_wait, memw} = '0;
    repeat (3) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (4) step();
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      slave(seed[0], (k < 3) ? 2'(k) : 2'(seed[2:1] % 3), seed[15:8], seed[31:16]);
    end
    n = req_n;
    step();
    ds_n = 1'b0;
    repeat (8) step();
    check("refuse", {n, 2'b01}, {req_n, ack_oe, den_n});
    ds_n = 1'b1;
    for (int p = 0; p < 8; p++) begin
      repeat (3) step();
      pend = 3'(p);
      addr = (p == 6) ? 8'h7e : 8'h7f;
      repeat (4) step();
      check("irq", pend, irq_oe);
      n = iack_cnt;
      {iack_n, ds_n} = 2'b00;
      repeat (6) step();
      check("pass", exp_pass_n(addr[6:0] == HBS_IACK_ADDR, pend), pass_n);
      check("iack", n + int'(addr[6:0] == HBS_IACK_ADDR && p != 0), iack_cnt);
      {iack_n, ds_n} = 2'b11;
    end
    gforce = 1'b1;
    repeat (5) step();
    check("gpass_lo", 0, gpass_n);
    gforce = 1'b0;
    for (int k = 0; k < 4; k++) dma(k[0], k[1] ? 4'h5 : 4'h0);
    ack_off = 1'b1;
    step();
    dma_v = 1'b1;
    for (int i = 0; i < 30 && !(s_oe === 1'b1 && mds_n === 1'b0); i++) step();
    {dma_v, fault_n} = 2'b00;
    for (int i = 0; i < 10 && flt_cnt == 0; i++) step();
    repeat (3) step();
    check("fault", 4'h8, {flt_cnt == 1, mh_oe, s_oe, br_oe});
    {fault_n, ack_off} = 2'b10;
    stop_test();
  end
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule
